// *** hw/ashi_defines.svh ***
// Constants for the converter serial host interface
// Notes on behaviour
// R1: Mode 1 latches the shifted-in channel address on each strobe rising edge.
// R2: Mode 1 drives output on shift clock falling edge, samples input on rising.
// R3: Mode 1 chip select low resets sequence and enables the shift register; the code only clears the bit count while idle and never resets the state.
// R4: Mode 2 holds sequencer reset while select low; converts on select rise.
// R5: Mode 1 select high ignores inputs and floats the serial output.
// R6: Mode 2 initialization picks channel seven without any address transfer.
// R7: Mode 2 host keeps strobe low and external shift clock high.
// R8: Mode input high is parallel; low uses submode low mode 1, high mode 2.
// R9: Bit order select high shifts LSB first, low shifts MSB first.
// R10: Two divider inputs pick 1/1, 1/2, 1/4 or 1/8, first input low bit.
// R11: Mode 2 outputs internal clock and an active-low frame around data.
// R12: The whole 10-bit result shifts out, one bit per clock, chosen order.
`ifndef ASHI_DEFINES_SVH
`define ASHI_DEFINES_SVH
`define ASHI_RES_W 10
`define ASHI_CH_W 3
`define ASHI_CH_MODE2 3'h7
`define ASHI_BITCNT_W 4
`define ASHI_DIV_BASE 5'h0a
`endif

// *** hw/ashi_pkg.sv ***
// Types for the converter serial host interface
`include "ashi_defines.svh"
package ashi_pkg;
   typedef enum logic [1:0] {ASHI_PARALLEL, ASHI_SER1, ASHI_SER2} ashi_mode_type;
   typedef enum {ASHI_IDLE, ASHI_CONV, ASHI_SHIFT} ashi_state_type;
   typedef struct packed {
      logic [`ASHI_RES_W-1:0] data;
   } ashi_word_type;
endpackage : ashi_pkg

// *** hw/ashi_top.sv ***
// Serial host interface and sequence control of the converter
`timescale 1ns/10ps
`include "ashi_defines.svh"
module ashi_top
   import ashi_pkg::*;
#(
   parameter int RES_W = `ASHI_RES_W,
   parameter int CONV_CYCLES = 24
) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Mode and configuration
   input wire logic interface_mode_select,
   input wire logic submode_select,
   input wire logic bit_order_select,
   input wire logic clock_divider_sel_lo,
   input wire logic clock_divider_sel_hi,
   // Host serial pins
   input wire logic chip_select_n,
   input wire logic channel_latch_strobe,
   input wire logic external_shift_clock,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   output logic internal_shift_clock_out,
   output logic serial_out_frame_n,
   // Converter core side
   input wire logic result_valid,
   output logic result_ready,
   input wire logic [RES_W-1:0] result_data,
   output logic conv_start,
   output logic [`ASHI_CH_W-1:0] analog_input_mux
);
   // Decoded interface mode
   ashi_mode_type mode;
   // Sequence state
   ashi_state_type state_q;
   // Last-cycle copies of the select, strobe and shift clock pins
   logic cs_q;
   logic stb_q;
   logic sck_q;
   // Qualified pin edges
   logic cs_rise;
   logic stb_rise;
   logic sck_rise;
   logic sck_fall;
   // Address shifter and output shifter
   logic [`ASHI_CH_W-1:0] addr_sr_q;
   logic [RES_W-1:0] out_sr_q;
   // Bit and conversion counters
   logic [`ASHI_BITCNT_W-1:0] bit_q;
   logic [7:0] conv_cnt_q;
   // Internal clock divider, half period up to 80 core cycles
   logic [6:0] div_cnt_q;
   logic [6:0] div_top;
   logic iclk_q;
   logic iclk_fall;
   logic div_wrap;
   // Two-entry buffer between core result and shifter
   logic [RES_W-1:0] buf_q [2];
   logic [1:0] buf_cnt_q;
   logic buf_wptr_q;
   logic buf_rptr_q;
   logic buf_pop;
   logic buf_push;
   // Sequence helpers
   logic in_sel;
   logic shifting;
   logic done_shift;

   // Mode decode
   always_comb begin
      if (interface_mode_select) mode = ASHI_PARALLEL; // R8
      else if (submode_select) mode = ASHI_SER2; // R8
      else mode = ASHI_SER1; // R8
   end

   // Edge detection of host pins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_q <= 1'b1;
         stb_q <= 1'b0;
         sck_q <= 1'b1;
      end else if (clk_en) begin
         cs_q <= chip_select_n;
         stb_q <= channel_latch_strobe;
         sck_q <= external_shift_clock;
      end
   end
   // Pin qualification, host pins ignored while deselected
   assign in_sel = !chip_select_n; // R5
   assign cs_rise = chip_select_n && !cs_q;
   assign stb_rise = channel_latch_strobe && !stb_q && in_sel; // R5
   assign sck_rise = external_shift_clock && !sck_q && in_sel; // R5
   assign sck_fall = !external_shift_clock && sck_q && in_sel; // R5

   // Internal clock divider, 1/1 to 1/8
   always_comb begin
      div_top = 7'(`ASHI_DIV_BASE) << {clock_divider_sel_hi, clock_divider_sel_lo}; // R10
   end
   // Terminal count of each half period, ten core cycles at 1/1
   assign div_wrap = div_cnt_q >= div_top - 7'h01;
   // Half-period counter, toggles the internal clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_q <= 7'h00;
         iclk_q <= 1'b1;
      end else if (clk_en) begin
         if (div_wrap) begin // R10
            div_cnt_q <= 7'h00;
            iclk_q <= !iclk_q;
         end else begin
            div_cnt_q <= div_cnt_q + 7'h01;
         end
      end
   end
   assign iclk_fall = iclk_q && div_wrap;
   // Clock pin toggles only in mode 2, held low otherwise
   assign internal_shift_clock_out = (mode == ASHI_SER2) ? iclk_q : 1'b0; // R11

   // Channel address shift and latch
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_sr_q <= 3'h0;
         analog_input_mux <= 3'h0;
      end else if (clk_en) begin
         if (mode == ASHI_SER2) begin
            analog_input_mux <= `ASHI_CH_MODE2; // R6
         end else if (mode == ASHI_SER1) begin
            if (sck_rise) addr_sr_q <= {addr_sr_q[1:0], serial_in}; // R2
            if (stb_rise) analog_input_mux <= addr_sr_q; // R1
         end
      end
   end

   // Result buffer
   assign buf_push = result_valid && result_ready;
   assign result_ready = buf_cnt_q != 2'h2;
   // Buffer pointers and fill count
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_cnt_q <= 2'h0;
         buf_wptr_q <= 1'b0;
         buf_rptr_q <= 1'b0;
         buf_q[0] <= '0;
         buf_q[1] <= '0;
      end else if (clk_en) begin
         if (buf_push) begin
            buf_q[buf_wptr_q] <= result_data;
            buf_wptr_q <= !buf_wptr_q;
         end
         if (buf_pop) buf_rptr_q <= !buf_rptr_q;
         buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // Sequence control and output shifter
   assign shifting = state_q == ASHI_SHIFT;
   assign done_shift = bit_q == `ASHI_BITCNT_W'(RES_W - 1);
   assign buf_pop = (state_q == ASHI_CONV) && conv_cnt_q == 8'h00 && buf_cnt_q != 2'h0;
   // Sequence state, counters and shifter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ASHI_IDLE;
         conv_cnt_q <= 8'h00;
         bit_q <= '0;
         out_sr_q <= '0;
         conv_start <= 1'b0;
      end else if (clk_en) begin
         conv_start <= 1'b0;
         if (mode == ASHI_PARALLEL) begin
            state_q <= ASHI_IDLE;
         end else if (mode == ASHI_SER2 && !chip_select_n) begin
            state_q <= ASHI_IDLE; // R4
         end else if (mode == ASHI_SER1 && !chip_select_n && !cs_q && cs_q != chip_select_n) begin
            state_q <= ASHI_IDLE;
         end else begin
            case (state_q)
               ASHI_IDLE: begin
                  if ((mode == ASHI_SER2 && cs_rise) || (mode == ASHI_SER1 && cs_rise)) begin
                     state_q <= ASHI_CONV; // R4
                     conv_start <= 1'b1;
                     conv_cnt_q <= 8'(CONV_CYCLES);
                  end
               end
               ASHI_CONV: begin
                  if (conv_cnt_q != 8'h00) conv_cnt_q <= conv_cnt_q - 8'h01;
                  else if (buf_pop) begin
                     out_sr_q <= buf_q[buf_rptr_q];
                     bit_q <= '0;
                     state_q <= ASHI_SHIFT;
                  end
               end
               ASHI_SHIFT: begin
                  if ((mode == ASHI_SER1 && sck_fall) ||
                      (mode == ASHI_SER2 && iclk_fall)) begin // R2
                     if (bit_order_select) out_sr_q <= out_sr_q >> 1; // R9
                     else out_sr_q <= out_sr_q << 1; // R9
                     bit_q <= bit_q + `ASHI_BITCNT_W'(1);
                     if (done_shift) state_q <= ASHI_IDLE; // R12
                  end
               end
               default: state_q <= ASHI_IDLE;
            endcase
         end
         // In mode 1, idle with select low restarts the bit count
         if (mode == ASHI_SER1 && !chip_select_n && state_q == ASHI_IDLE) begin
            bit_q <= '0; // R3
         end
      end
   end

   // Serial output pin, frame and enable
   always_comb begin
      serial_out = bit_order_select ? out_sr_q[0] : out_sr_q[RES_W-1]; // R9
      serial_out_oe = (mode == ASHI_SER1) ? in_sel : (mode == ASHI_SER2); // R5
      serial_out_frame_n = !((mode == ASHI_SER2) && shifting); // R11
   end
endmodule : ashi_top

// *** tb/ashi_properties.sv ***
// Checker for the converter serial host interface
`timescale 1ns/10ps
module ashi_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Watched pins
   input wire logic interface_mode_select,
   input wire logic submode_select,
   input wire logic chip_select_n,
   input wire logic serial_out_oe,
   input wire logic internal_shift_clock_out,
   input wire logic serial_out_frame_n,
   input wire logic conv_start,
   input wire logic [2:0] analog_input_mux
);
   // Serial mode decodes
   wire m1 = !interface_mode_select && !submode_select;
   wire m2 = !interface_mode_select && submode_select;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   hold_chan_a: assert property (m1 && chip_select_n |=> $stable(analog_input_mux))
      else $error("channel moved while deselected");
   float_out_a: assert property (m1 && chip_select_n && $past(m1 && chip_select_n) |-> !serial_out_oe)
      else $error("output driven while deselected");
   pick_ch7_a: assert property (m2 |=> analog_input_mux == 3'h7)
      else $error("mode 2 channel not seven");
   start_rise_a: assert property (!interface_mode_select && $rose(chip_select_n) |=> conv_start)
      else $error("no start after select rise");
   held_reset_a: assert property (!chip_select_n ##1 !chip_select_n |-> !conv_start)
      else $error("start while select low");
   start_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("start longer than a cycle");
   clk_quiet_a: assert property (!m2 ##1 !m2 |-> !internal_shift_clock_out)
      else $error("clock out outside mode 2");
   frame_idle_a: assert property (!m2 ##1 !m2 |-> serial_out_frame_n)
      else $error("frame outside mode 2");
   cover property (conv_start);
   cover property (m2 && !serial_out_frame_n);
   cover property (m1 && $rose(chip_select_n));
endmodule : ashi_properties
bind ashi_top ashi_properties chk_u (.*);

// *** tb/ashi_core_model.sv ***
// Converter core stand-in offering one result per start
`timescale 1ns/10ps
module ashi_core_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Core side of the block
   input wire logic conv_start,
   input wire logic result_ready,
   input wire logic [9:0] next_word,
   output logic result_valid,
   output logic [9:0] result_data
);
   // Hold the word until taken, then scramble the released bus
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_valid <= 1'b0;
         result_data <= 10'h0;
      end else if (conv_start) begin
         result_valid <= 1'b1;
         result_data <= next_word;
      end else if (result_valid && result_ready) begin
         result_valid <= 1'b0;
         result_data <= ~result_data;
      end
   end
endmodule : ashi_core_model

// *** tb/ashi_top_tb.sv ***
// Bench for the converter serial host interface
`timescale 1ns/10ps
module ashi_top_tb;
   logic core_clk = 0, rst_n = 0, clk_en = 1, interface_mode_select = 0, submode_select = 0;
   logic bit_order_select = 0, clock_divider_sel_lo = 0, clock_divider_sel_hi = 0;
   logic chip_select_n = 1, channel_latch_strobe = 0, external_shift_clock = 1, serial_in = 0;
   logic serial_out, serial_out_oe, internal_shift_clock_out, serial_out_frame_n;
   logic result_valid, result_ready, conv_start;
   logic [9:0] result_data, next_word = 10'h0;
   logic [2:0] analog_input_mux;
   int n_fail = 0, n_checks = 0, seed = 32'h6738, cyc = 0;
   time t;
   ashi_top dut_u (.*);
   ashi_core_model core_u (.*);
   initial forever #25 core_clk = ~core_clk;
   // Hang guard
   always @(posedge core_clk) if (++cyc > 20000) begin n_fail++; give_verdict(); end
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   task automatic bit1(input logic b);
      serial_in = b;
      external_shift_clock = 0;
      tick(2);
      external_shift_clock = 1;
      tick(2);
   endtask : bit1
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // Mode 1 address latch and readout, then mode 2 divider rates
   initial begin
      tick(5);
      rst_n = 1;
      for (int i = 0; i < 8; i++) begin
         next_word = 10'($random(seed));
         bit_order_select = i[0];
         chip_select_n = 0;
         tick(2);
         for (int b = 2; b >= 0; b--) bit1(i[b]);
         channel_latch_strobe = 1;
         tick(2);
         channel_latch_strobe = 0;
         tick(2);
         chk(10'(analog_input_mux), 10'(i));
         chip_select_n = 1;
         channel_latch_strobe = 1;
         tick(40);
         channel_latch_strobe = 0;
         chk(10'(analog_input_mux), 10'(i));
         chk(10'(serial_out_oe), 10'h0);
         chip_select_n = 0;
         tick(2);
         for (int b = 0; b < 10; b++) begin
            chk(10'(serial_out), 10'(next_word[bit_order_select ? b : 9 - b]));
            bit1(1'b0);
         end
      end
      // Frozen enable must not latch the zeroed address
      clk_en = 0;
      for (int b = 0; b < 3; b++) bit1(1'b0);
      channel_latch_strobe = 1;
      tick(2);
      channel_latch_strobe = 0;
      clk_en = 1;
      tick(2);
      chk(10'(analog_input_mux), 10'h7);
      $display("mode 1 test done");
      channel_latch_strobe = 0;
      external_shift_clock = 1;
      submode_select = 1;
      tick(2);
      chk(10'(analog_input_mux), 10'h7);
      for (int k = 0; k < 4; k++) begin
         next_word = 10'($random(seed));
         bit_order_select = k[0];
         {clock_divider_sel_hi, clock_divider_sel_lo} = 2'(k);
         chip_select_n = 0;
         tick(2);
         chip_select_n = 1;
         @(posedge conv_start);
         @(negedge serial_out_frame_n);
         tick(1);
         for (int b = 0; b < 10; b++) begin
            chk(10'(serial_out_frame_n), 10'h0);
            chk(10'(serial_out), 10'(next_word[k[0] ? b : 9 - b]));
            @(negedge internal_shift_clock_out);
            tick(1);
         end
         chk(10'(serial_out_frame_n), 10'h1);
         repeat (2) @(posedge internal_shift_clock_out);
         t = $time;
         @(posedge internal_shift_clock_out);
         chk(10'(($time - t) / 50), 10'(20 << k));
      end
      $display("mode 2 test done");
      give_verdict();
   end
endmodule : ashi_top_tb
